// [cvpm_regs.vh]
// Constants for the drive-interface pin multiplexer and volume-button logic.
// Assumes an including module that runs on one 200 MHz clock.
`ifndef CVPM_REGS_VH
`define CVPM_REGS_VH
`define CVPM_PORT_DEFAULT      12'h279
`define CVPM_PORT_ALT_HIGH     12'h308
`define CVPM_PORT_ALT_LOW      12'h388
`define CVPM_CLK_PERIOD_PS     5000
`define CVPM_DEBOUNCE_US       10
`define CVPM_DEBOUNCE_CYC      ((`CVPM_DEBOUNCE_US * 1000000) / `CVPM_CLK_PERIOD_PS)
`define CVPM_VOL_MAX           6'h3f
`define CVPM_VOL_MIN           6'h00
`define CVPM_VOL_RESET         6'h20
`define CVPM_BTN_UP            0
`define CVPM_BTN_DOWN          1
`define CVPM_BTN_MUTE          2
`endif

// [cvpm_pin_mux.v]
// Pin-function multiplexer for the drive interface, shared output pin and volume buttons.
// Assumes all inputs are synchronous to sys_clk_i and strap pins are stable at reset release.
`timescale 1ns/1ps
`include "cvpm_regs.vh"

// What this block does
// - After reset the shared pin is a general output following the codec register ten bit.
// - A low serial-out strap turns the shared pin into an alternate drive select on base match.
// - The volume-pins enable makes the shared pin the volume-down input, above all else.
// - The drive interrupt is forwarded to the host interrupt line chosen by configuration.
// - The drive interrupt polarity is selectable and defaults to active high.
// - The drive DMA request is forwarded to the host DMA request line chosen by configuration.
// - The host DMA acknowledge for the drive channel is presented on the drive acknowledge.
// - Volume buttons act only while enabled, in the format chosen by the format setting.
// - A low volume-up input raises master volume of both channels.
// - A low volume-down input lowers master volume of both channels.
// - The mute input is momentary or has no effect, per the format setting.
// - With the port strap high the configuration port sits at 279h.
// - With the port strap low the serial clock is sampled at reset release: high 308h, low 388h.
// - The four drive pins are host upper address inputs unless the drive strap reads low.
// - The primary drive select goes low when the host address matches the drive base.
module cvpm_pin_mux #(
	parameter                    DEBOUNCE_CYC = `CVPM_DEBOUNCE_CYC,
	parameter                    ADDR_W       = 16,
	parameter                    BASE_MASK_W  = 3,
	parameter                    NUM_IRQ      = 16,
	parameter                    NUM_DRQ      = 8
) (
	input  wire                  sys_clk_i,
	input  wire                  rst_n_i,
	input  wire                  clk_en_i,
	input  wire                  gp_output_one_i,
	input  wire                  serial_out_strap_pin_i,
	input  wire                  drive_strap_pin_i,
	input  wire                  config_port_strap_i,
	input  wire                  serial_clock_pin_i,
	input  wire                  volume_pins_enable_i,
	input  wire                  volume_pin_format_i,
	input  wire [ADDR_W-1:0]     host_addr_i,
	input  wire                  host_aen_i,
	input  wire [ADDR_W-1:0]     drive_base_addr_i,
	input  wire [ADDR_W-1:0]     alt_drive_base_addr_i,
	input  wire                  drive_irq_in_i,
	input  wire                  drive_irq_polarity_i,
	input  wire [3:0]            drive_irq_sel_i,
	input  wire                  drive_irq_en_i,
	input  wire                  drive_dma_req_in_i,
	input  wire [2:0]            drive_dma_sel_i,
	input  wire                  drive_dma_en_i,
	input  wire [NUM_DRQ-1:0]    host_dack_n_i,
	input  wire                  shared_pin_in_i,
	input  wire                  vol_up_n_i,
	input  wire                  vol_mute_n_i,
	output reg                   shared_pin_out_o,
	output reg                   shared_pin_oe_o,
	output reg                   serial_clock_pin_oe_o,
	output reg                   drive_pins_active_o,
	output reg                   drive_select_out_n_o,
	output reg                   alt_drive_select_out_n_o,
	output reg  [NUM_IRQ-1:0]    host_irq_o,
	output reg  [NUM_DRQ-1:0]    host_drq_o,
	output reg                   drive_dma_ack_out_n_o,
	output reg  [11:0]           config_port_addr_o,
	output reg  [5:0]            master_vol_left_o,
	output reg  [5:0]            master_vol_right_o,
	output reg                   master_mute_o
);

	localparam CNT_W = 24;
	localparam [31:0]      DB_LAST_W = DEBOUNCE_CYC - 1;
	localparam [CNT_W-1:0] DB_LAST   = DB_LAST_W[CNT_W-1:0];
	localparam [1:0] ST_RESET = 2'b01;
	localparam [1:0] ST_RUN   = 2'b10;

	reg  [1:0]  state_reg;
	reg         alt_strap_reg;
	reg  [2:0]  btn_meta_reg;
	reg  [2:0]  btn_sync_reg;
	reg  [2:0]  btn_stable_reg;
	reg  [2:0]  btn_press_reg;
	reg  [5:0]  vol_reg;
	wire [2:0]  btn_raw_n;
	wire        irq_active;
	wire        drive_match;
	wire        alt_match;

	// Address decode against a base with the low bits of the window ignored.
	function base_hit;
		input [ADDR_W-1:0] addr;
		input [ADDR_W-1:0] base;
		begin
			base_hit = (addr[ADDR_W-1:BASE_MASK_W] == base[ADDR_W-1:BASE_MASK_W]);
		end
	endfunction

	// The volume-down button shares the multiplexed pin.
	assign btn_raw_n   = {vol_mute_n_i, shared_pin_in_i, vol_up_n_i};
	assign irq_active  = drive_irq_polarity_i ? ~drive_irq_in_i : drive_irq_in_i;
	assign drive_match = !host_aen_i && base_hit(host_addr_i, drive_base_addr_i);
	assign alt_match   = !host_aen_i && base_hit(host_addr_i, alt_drive_base_addr_i);

	// Straps are caught on the first enabled edge after reset release, never under reset.
	// Until then every pin keeps its default function.
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_reg             <= ST_RESET;
			alt_strap_reg         <= 1'b0;
			drive_pins_active_o   <= 1'b0;
			config_port_addr_o    <= `CVPM_PORT_DEFAULT;
			serial_clock_pin_oe_o <= 1'b0;
		end else if (clk_en_i) begin
			case (state_reg)
				ST_RESET: begin
					state_reg           <= ST_RUN;
					alt_strap_reg       <= !serial_out_strap_pin_i;
					drive_pins_active_o <= !drive_strap_pin_i;
					// The port strap wins; the serial clock is looked at only when it is low.
					if (config_port_strap_i)
						config_port_addr_o <= `CVPM_PORT_DEFAULT;
					else if (serial_clock_pin_i)
						config_port_addr_o <= `CVPM_PORT_ALT_HIGH;
					else
						config_port_addr_o <= `CVPM_PORT_ALT_LOW;
				end
				ST_RUN: begin
					state_reg <= ST_RUN;
				end
				default: begin
					state_reg <= ST_RESET;
				end
			endcase
			// Serial clock stays an input throughout; its output use belongs elsewhere.
			serial_clock_pin_oe_o <= 1'b0;
		end
	end

	// Shared pin and drive pass-through.
	// In volume mode the pin is released rather than driven, so the button can pull it low.
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			shared_pin_out_o         <= 1'b0;
			shared_pin_oe_o          <= 1'b1;
			drive_select_out_n_o     <= 1'b1;
			alt_drive_select_out_n_o <= 1'b1;
			host_irq_o               <= {NUM_IRQ{1'b0}};
			host_drq_o               <= {NUM_DRQ{1'b0}};
			drive_dma_ack_out_n_o    <= 1'b1;
		end else if (clk_en_i) begin
			if (volume_pins_enable_i) begin
				shared_pin_oe_o  <= 1'b0;
				shared_pin_out_o <= 1'b0;
			end else if (alt_strap_reg && state_reg == ST_RUN) begin
				shared_pin_oe_o  <= 1'b1;
				shared_pin_out_o <= !alt_match;
			end else begin
				shared_pin_oe_o  <= 1'b1;
				shared_pin_out_o <= gp_output_one_i;
			end
			// The dedicated alternate select stays high whenever the shared pin is not a select.
			alt_drive_select_out_n_o <= !(alt_strap_reg && !volume_pins_enable_i && alt_match);
			drive_select_out_n_o     <= !(drive_pins_active_o && drive_match);
			// At most one host line is raised for the drive, chosen by the configuration selects.
			host_irq_o <= (drive_pins_active_o && drive_irq_en_i && irq_active) ?
				({{(NUM_IRQ-1){1'b0}}, 1'b1} << drive_irq_sel_i) : {NUM_IRQ{1'b0}};
			host_drq_o <= (drive_pins_active_o && drive_dma_en_i && drive_dma_req_in_i) ?
				({{(NUM_DRQ-1){1'b0}}, 1'b1} << drive_dma_sel_i) : {NUM_DRQ{1'b0}};
			drive_dma_ack_out_n_o <= !(drive_pins_active_o && drive_dma_en_i &&
				!host_dack_n_i[drive_dma_sel_i]);
		end
	end

	// Each button: two-flop synchroniser, then a hold counter before the level is accepted.
	// Any return of the synchronised level to the accepted one restarts the count, so bounce
	// shorter than the hold window never steps the volume.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_btn
			reg [CNT_W-1:0] cnt_reg;
			always @(posedge sys_clk_i) begin
				if (!rst_n_i) begin
					btn_meta_reg[gi]   <= 1'b0;
					btn_sync_reg[gi]   <= 1'b0;
					btn_stable_reg[gi] <= 1'b0;
					btn_press_reg[gi]  <= 1'b0;
					cnt_reg            <= {CNT_W{1'b0}};
				end else if (clk_en_i) begin
					btn_meta_reg[gi]  <= !btn_raw_n[gi] && volume_pins_enable_i;
					btn_sync_reg[gi]  <= btn_meta_reg[gi];
					btn_press_reg[gi] <= 1'b0;
					if (btn_sync_reg[gi] == btn_stable_reg[gi]) begin
						cnt_reg <= {CNT_W{1'b0}};
					end else if (cnt_reg == DB_LAST) begin
						cnt_reg            <= {CNT_W{1'b0}};
						btn_stable_reg[gi] <= btn_sync_reg[gi];
						btn_press_reg[gi]  <= btn_sync_reg[gi];
					end else begin
						cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
					end
				end
			end
		end
	endgenerate

	// One step per accepted press; up wins if both land together below the maximum, and limits saturate.
	// A held button gives a single step; there is no auto-repeat while it stays down.
	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			vol_reg            <= `CVPM_VOL_RESET;
			master_vol_left_o  <= `CVPM_VOL_RESET;
			master_vol_right_o <= `CVPM_VOL_RESET;
			master_mute_o      <= 1'b0;
		end else if (clk_en_i) begin
			if (btn_press_reg[`CVPM_BTN_UP] && vol_reg != `CVPM_VOL_MAX)
				vol_reg <= vol_reg + 6'h01;
			else if (btn_press_reg[`CVPM_BTN_DOWN] && vol_reg != `CVPM_VOL_MIN)
				vol_reg <= vol_reg - 6'h01;
			master_vol_left_o  <= vol_reg;
			master_vol_right_o <= vol_reg;
			// Momentary mute follows the held button; the other format ignores it.
			master_mute_o <= volume_pin_format_i && btn_stable_reg[`CVPM_BTN_MUTE];
		end
	end

endmodule

// [cvpm_drive_model.sv]
// Behavioural drive on the far side of the multiplexer: interrupt and DMA request levels.
// Assumes the bench commands it just after the rising clock edge.
`timescale 1ns/1ps
module cvpm_drive_model (
	input  wire logic sys_clk_i,
	input  wire logic irq_req_i,
	input  wire logic drq_req_i,
	output logic      drive_irq_o = 1'h0,
	output logic      drive_drq_o = 1'h0
);
	always @(posedge sys_clk_i) begin
		drive_irq_o <= irq_req_i;
		drive_drq_o <= drq_req_i;
	end
endmodule

// [cvpm_checker.sv]
// Checker for the multiplexer: decode, routing, straps and volume.
// Assumes a bind onto cvpm_pin_mux with its default widths.
`timescale 1ns/1ps
module cvpm_checker (
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic        clk_en_i,
	input wire logic        gp_output_one_i,
	input wire logic        host_aen_i,
	input wire logic        serial_out_strap_pin_i,
	input wire logic        config_port_strap_i,
	input wire logic        serial_clock_pin_i,
	input wire logic        volume_pins_enable_i,
	input wire logic        drive_irq_in_i,
	input wire logic        drive_irq_polarity_i,
	input wire logic        drive_irq_en_i,
	input wire logic        drive_dma_req_in_i,
	input wire logic        drive_dma_en_i,
	input wire logic        shared_pin_out_o,
	input wire logic        shared_pin_oe_o,
	input wire logic        drive_pins_active_o,
	input wire logic        drive_select_out_n_o,
	input wire logic        drive_dma_ack_out_n_o,
	input wire logic [15:0] host_addr_i,
	input wire logic [15:0] drive_base_addr_i,
	input wire logic [15:0] host_irq_o,
	input wire logic [3:0]  drive_irq_sel_i,
	input wire logic [2:0]  drive_dma_sel_i,
	input wire logic [7:0]  host_dack_n_i,
	input wire logic [7:0]  host_drq_o,
	input wire logic [11:0] config_port_addr_o,
	input wire logic [5:0]  master_vol_left_o,
	input wire logic [5:0]  master_vol_right_o
);
	wire live = clk_en_i && drive_pins_active_o;
	wire hit  = live && !host_aen_i && host_addr_i[15:3] == drive_base_addr_i[15:3];
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sel_decode_a: assert property (hit |=> !drive_select_out_n_o)
		else $error("drive select missed a match");
	irq_route_a: assert property (live && drive_irq_en_i |=> host_irq_o ==
		({15'h0, $past(drive_irq_in_i) ^ $past(drive_irq_polarity_i)} << $past(drive_irq_sel_i)))
		else $error("interrupt routed wrongly");
	drq_route_a: assert property (live && drive_dma_en_i |=> host_drq_o ==
		({7'h0, $past(drive_dma_req_in_i)} << $past(drive_dma_sel_i))) else $error("bad request");
	ack_pass_a: assert property (live && drive_dma_en_i |=> drive_dma_ack_out_n_o ==
		(($past(host_dack_n_i) >> $past(drive_dma_sel_i)) & 8'h01)) else $error("bad acknowledge");
	vol_wins_a: assert property (clk_en_i && volume_pins_enable_i |=> !shared_pin_oe_o)
		else $error("shared pin driven while volume pins enabled");
	gp_follow_a: assert property (clk_en_i && !volume_pins_enable_i && serial_out_strap_pin_i
		|=> shared_pin_oe_o && shared_pin_out_o == $past(gp_output_one_i)) else $error("bad output");
	port_alt_a: assert property ($rose(rst_n_i) && !config_port_strap_i |=>
		config_port_addr_o == ($past(serial_clock_pin_i) ? 12'h308 : 12'h388)) else $error("bad port");
	port_std_a: assert property (config_port_strap_i |-> config_port_addr_o == 12'h279)
		else $error("standard port wrong");
	vol_pair_a: assert property (master_vol_left_o == master_vol_right_o)
		else $error("channel volumes differ");
	vol_idle_a: assert property (!volume_pins_enable_i [*8] |-> $stable(master_vol_left_o))
		else $error("volume moved while buttons disabled");
	vol_step_a: assert property (master_vol_left_o != $past(master_vol_left_o) |->
		master_vol_left_o == $past(master_vol_left_o) + 6'h01 ||
		master_vol_left_o == $past(master_vol_left_o) - 6'h01)
		else $error("volume jumped by more than one step");
endmodule
bind cvpm_pin_mux cvpm_checker chk (.*);

// [tb_top.sv]
// Self-checking bench for cvpm_pin_mux with a behavioural drive on the far side.
// Assumes the checker is bound separately; clk_en_i drops only for one short freeze test.
`timescale 1ns/1ps
module tb_top;
	logic        sys_clk_i = 0, rst_n_i = 0, clk_en_i = 1, gp_output_one_i = 0, host_aen_i = 0;
	logic        serial_out_strap_pin_i = 1, drive_strap_pin_i = 0, config_port_strap_i = 0;
	logic        serial_clock_pin_i = 1, volume_pins_enable_i = 0, volume_pin_format_i = 0;
	logic        drive_irq_in_i, drive_irq_polarity_i = 0, drive_irq_en_i = 1, drive_dma_req_in_i;
	logic        drive_dma_en_i = 1, shared_pin_in_i = 1, vol_up_n_i = 1, vol_mute_n_i = 1;
	logic        irq_req = 0, drq_req = 0;
	logic [15:0] host_addr_i = 16'h0, drive_base_addr_i = 16'h0340, alt_drive_base_addr_i = 16'h0170;
	logic [3:0]  drive_irq_sel_i = 4'h0;
	logic [2:0]  drive_dma_sel_i = 3'h0;
	logic [7:0]  host_dack_n_i = 8'hff;
	wire         shared_pin_out_o, shared_pin_oe_o, serial_clock_pin_oe_o, drive_pins_active_o;
	wire         drive_select_out_n_o, alt_drive_select_out_n_o, drive_dma_ack_out_n_o, master_mute_o;
	wire [15:0]  host_irq_o;
	wire [7:0]   host_drq_o;
	wire [11:0]  config_port_addr_o;
	wire [5:0]   master_vol_left_o, master_vol_right_o;
	int          n_fail = 0, cmp_count = 0;
	// Row: irq, polarity, irq line, drq, dma channel, acks, then expected irq, drq, ack.
	logic [42:0] rows [4] = '{{1'h1, 1'h0, 4'h5, 1'h1, 3'h3, 8'hf7, 16'h0020, 8'h08, 1'h0},
		{1'h0, 1'h1, 4'hf, 1'h0, 3'h0, 8'hfe, 16'h8000, 8'h00, 1'h0},
		{1'h1, 1'h1, 4'h9, 1'h1, 3'h7, 8'hff, 16'h0000, 8'h80, 1'h1},
		{1'h0, 1'h0, 4'h2, 1'h1, 3'h0, 8'h7f, 16'h0000, 8'h01, 1'h1}};
	cvpm_pin_mux #(.DEBOUNCE_CYC(4)) uut (.*);
	cvpm_drive_model drv (.sys_clk_i(sys_clk_i), .irq_req_i(irq_req), .drq_req_i(drq_req),
		.drive_irq_o(drive_irq_in_i), .drive_drq_o(drive_dma_req_in_i));
	initial forever #2.5 sys_clk_i = ~sys_clk_i;
	task automatic step;
		@(posedge sys_clk_i);
		#1;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic rst_seq;
		rst_n_i = 0;
		repeat (12) step;
		rst_n_i = 1;
		repeat (3) step;
	endtask
	// Holding 12 cycles covers two sync flops plus the shortened debounce.
	task automatic press(input logic [1:0] b);
		{vol_mute_n_i, shared_pin_in_i, vol_up_n_i} = ~(3'h1 << b);
		repeat (12) step;
		{vol_mute_n_i, shared_pin_in_i, vol_up_n_i} = 3'h7;
		repeat (6) step;
	endtask
	initial begin
		rst_seq;
		chk(config_port_addr_o, 12'h308);
		chk(drive_pins_active_o, 1'h1);
		chk(serial_clock_pin_oe_o, 1'h0);
		for (int i = 0; i < 4; i++) begin
			{irq_req, drive_irq_polarity_i, drive_irq_sel_i, drq_req} = rows[i][42:36];
			{drive_dma_sel_i, host_dack_n_i} = rows[i][35:25];
			repeat (3) step;
			chk(host_irq_o, rows[i][24:9]);
			chk(host_drq_o, rows[i][8:1]);
			chk(drive_dma_ack_out_n_o, rows[i][0]);
		end
		host_addr_i = 16'h0347;
		repeat (2) step;
		chk(drive_select_out_n_o, 1'h0);
		host_aen_i = 1;
		gp_output_one_i = 1;
		repeat (2) step;
		chk(drive_select_out_n_o, 1'h1);
		chk({shared_pin_oe_o, shared_pin_out_o}, 2'h3);
		clk_en_i = 0;
		gp_output_one_i = 0;
		repeat (3) step;
		chk(shared_pin_out_o, 1'h1);
		clk_en_i = 1;
		repeat (2) step;
		chk(shared_pin_out_o, 1'h0);
		press(0);
		chk(master_vol_left_o, 6'h20);
		volume_pins_enable_i = 1;
		press(0);
		chk(shared_pin_oe_o, 1'h0);
		chk({master_vol_left_o, master_vol_right_o}, 12'h861);
		press(1);
		chk({master_vol_left_o, master_vol_right_o}, 12'h820);
		press(2);
		chk(master_mute_o, 1'h0);
		vol_mute_n_i = 0;
		repeat (8) step;
		chk(master_mute_o, 1'h0);
		volume_pin_format_i = 1;
		repeat (2) step;
		chk(master_mute_o, 1'h1);
		vol_mute_n_i = 1;
		repeat (8) step;
		chk(master_mute_o, 1'h0);
		repeat (40) press(0);
		chk(master_vol_left_o, 6'h3f);
		repeat (70) press(1);
		chk(master_vol_right_o, 6'h00);
		{serial_out_strap_pin_i, drive_strap_pin_i, config_port_strap_i} = 3'h3;
		{volume_pins_enable_i, host_aen_i, host_addr_i} = {2'h0, alt_drive_base_addr_i};
		rst_seq;
		chk(config_port_addr_o, 12'h279);
		chk(drive_pins_active_o, 1'h0);
		chk(host_drq_o, 8'h00);
		chk({alt_drive_select_out_n_o, shared_pin_out_o, shared_pin_oe_o}, 3'h1);
		{config_port_strap_i, serial_clock_pin_i} = 2'h0;
		rst_seq;
		chk(config_port_addr_o, 12'h388);
		results;
	end
	initial begin
		#100000;
		n_fail++;
		results;
	end
endmodule
